// file: src/iox_cfg.svh
/*
 offsets, field positions, reset values and timing counts of the expander bus host.
 assumes a 50 MHz system clock and an 8-bit register address on the software port.
*/
`ifndef IOX_CFG_SVH
`define IOX_CFG_SVH

// software register offsets
`define IOX_OFF_CTRL 8'h00
`define IOX_OFF_ADDR 8'h04
`define IOX_OFF_LEN 8'h08
`define IOX_OFF_WDATA 8'h0C
`define IOX_OFF_RDATA 8'h10
`define IOX_OFF_STAT 8'h14

// control register fields
`define IOX_CTRL_GO 0
`define IOX_CTRL_RD 1
`define IOX_CTRL_SKIP 2
`define IOX_CTRL_ABORT 3
`define IOX_CTRL_PTR_LO 4
`define IOX_CTRL_PTR_HI 6

// status register fields
`define IOX_STAT_BUSY 0
`define IOX_STAT_NACK 1
`define IOX_STAT_INT 2
`define IOX_STAT_IDLE 3
`define IOX_STAT_REFUSED 4

// reset values
`define IOX_RST_ADDR 7'h00
`define IOX_RST_LEN 8'h01
`define IOX_RST_PTR 3'h0

// bus direction bit appended to the slave address
`define IOX_DIR_WRITE 1'b0
`define IOX_DIR_READ 1'b1

// timing
`define IOX_CLK_MHZ 50
`define IOX_SCL_PERIOD_NS 10000
`define IOX_QTR_CYC ((`IOX_SCL_PERIOD_NS * `IOX_CLK_MHZ) / 4000)

`endif

// file: src/iox_pkg.sv
/*
 types shared by the expander bus host, its checker and its bench.
 assumes iox_cfg.svh is on the include path.
*/
package iox_pkg;

    typedef logic [7:0] iox_byte_t;
    typedef logic [15:0] iox_word_t;
    typedef logic [6:0] iox_saddr_t;

    typedef enum logic [1:0] {
        IOX_IDLE,
        IOX_START,
        IOX_BIT,
        IOX_STOP
    } iox_state_e;

    typedef enum logic [2:0] {
        IOX_PH_ADDR_W,
        IOX_PH_CMD,
        IOX_PH_WDATA,
        IOX_PH_ADDR_R,
        IOX_PH_RDATA
    } iox_phase_e;

    typedef struct packed {
        iox_state_e st;
        iox_phase_e ph;
        logic [1:0] q;
        logic [15:0] tcnt;
        logic [3:0] bitn;
        iox_byte_t sh;
        iox_byte_t remain;
        logic slot;
        logic ack;
        logic busy;
        logic nack;
        logic refused;
        logic abort;
        logic rd;
        logic skip;
        logic [2:0] ptr;
        iox_saddr_t saddr;
        iox_byte_t len;
        iox_word_t wdata;
        iox_word_t rdata;
        iox_word_t bus_rdata;
        logic scl_o;
        logic scl_oe_n;
        logic sda_o;
        logic sda_oe_n;
    } iox_host_s;

endpackage

// file: src/iox_sync.sv
/*
 two-flop synchroniser, one chain per bit.
 assumes inputs come from outside the clk domain.
*/
`timescale 1ns/1ps
module iox_sync #(
    parameter int W = 3
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } iox_sync_s;

    iox_sync_s s_r;
    iox_sync_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        for (int i = 0; i < W; i++) begin
            s_nxt.s1[i] = d[i];
            s_nxt.s2[i] = s_r.s1[i];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.s2;
endmodule // iox_sync

// file: src/iox_host.sv
/*
 bus host for a 16-bit i2c port expander: software orders a register write or read,
 the block runs start, address, command byte, data bytes and stop on scl/sda.
 assumes open-drain pins resolved outside (low when oe_n is low), pull-ups on both
 lines, and an expander that keeps its own register pointer and pair toggling.
*/
// What the document requires of the bus, the host and the device
// [R01] write: address with lsb 0, then command
// [R02] device toggles register within pair per byte
// [R03] any number of write bytes, alternating pair
// [R04] read: command, repeated start, address lsb 1
// [R05] device loads transmit data at ack fall
// [R06] read bytes alternate between pair registers
// [R07] host withholds ack on final read byte
// [R08] stop may end transfer at any point
// [R09] device pulls interrupt low on input change
// [R10] interrupt clears on revert or port read
// [R11] output pins never raise the interrupt
// [R12] interrupt clearing tracked per 8-bit port
// [R13] output-to-input switch may raise interrupt
// [R14] sda changes only while scl low
// [R15] start is sda falling, scl high
// [R16] stop is sda rising, scl high
// [R17] nine clocks per byte, transmitter releases ack
// [R18] device acknowledges every received byte
// [R19] host acknowledges each read byte but last
// [R20] acknowledger holds sda low through ack high
// [R21] after nack, sda released for stop
// [R22] transfer starts only on idle bus
// [R23] command byte 0..7 selects register
// [R24] configuration bit 1 input, 0 output
// [R25] polarity bit 1 inverts input read
// [R26] unmatched address gets no ack, ignored
// [R27] pointer persists, read may skip command
`timescale 1ns/1ps
`include "iox_cfg.svh"
module iox_host #(
    parameter int QTR_CYC = `IOX_QTR_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire iox_pkg::iox_byte_t bus_addr,
    input wire iox_pkg::iox_word_t bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output iox_pkg::iox_word_t bus_rdata,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    input wire logic int_n_i
);
    import iox_pkg::*;

    iox_host_s s_r;
    iox_host_s s_nxt;
    logic [2:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic int_n_s;
    logic tick;
    logic abort_wr;

    iox_sync #(
        .W(3)
    ) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .d({int_n_i, sda_i, scl_i}),
        .q(pins_s)
    );

    assign scl_s = pins_s[0];
    assign sda_s = pins_s[1];
    assign int_n_s = pins_s[2];

    // byte to send for a transmit phase
    function automatic iox_byte_t tx_byte(input iox_host_s s, input iox_phase_e ph,
                                          input logic slot);
        iox_byte_t b;
        b = 8'h00;
        case (ph)
            IOX_PH_ADDR_W: b = {s.saddr, `IOX_DIR_WRITE}; // [R01]
            IOX_PH_ADDR_R: b = {s.saddr, `IOX_DIR_READ}; // [R04]
            IOX_PH_CMD: b = {5'h00, s.ptr}; // [R23]
            IOX_PH_WDATA: b = slot ? s.wdata[15:8] : s.wdata[7:0]; // [R03]
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    // software read decode
    function automatic iox_word_t reg_read(input iox_host_s s, input iox_byte_t a,
                                           input logic int_n, input logic idle);
        iox_word_t v;
        v = 16'h0000;
        case (a)
            `IOX_OFF_CTRL: begin
                v[`IOX_CTRL_RD] = s.rd;
                v[`IOX_CTRL_SKIP] = s.skip;
                v[`IOX_CTRL_ABORT] = s.abort;
                v[`IOX_CTRL_PTR_HI:`IOX_CTRL_PTR_LO] = s.ptr;
            end
            `IOX_OFF_ADDR: v = {9'h000, s.saddr};
            `IOX_OFF_LEN: v = {8'h00, s.len};
            `IOX_OFF_WDATA: v = s.wdata;
            `IOX_OFF_RDATA: v = s.rdata;
            `IOX_OFF_STAT: begin
                v[`IOX_STAT_BUSY] = s.busy;
                v[`IOX_STAT_NACK] = s.nack;
                v[`IOX_STAT_INT] = ~int_n; // [R09]
                v[`IOX_STAT_IDLE] = idle;
                v[`IOX_STAT_REFUSED] = s.refused;
            end
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    assign tick = (s_r.st != IOX_IDLE) && (s_r.tcnt == 16'(QTR_CYC - 1));
    assign abort_wr = bus_wr && (bus_addr == `IOX_OFF_CTRL) && bus_wdata[`IOX_CTRL_ABORT];

    always_comb begin
        s_nxt = s_r;

        // software port
        if (bus_rd) begin
            s_nxt.bus_rdata = reg_read(s_r, bus_addr, int_n_s, scl_s & sda_s);
        end
        if (bus_wr) begin
            case (bus_addr)
                `IOX_OFF_CTRL: begin
                    if (s_r.busy) begin
                        if (bus_wdata[`IOX_CTRL_ABORT]) begin
                            s_nxt.abort = 1'b1; // [R08]
                        end
                    end else begin
                        s_nxt.rd = bus_wdata[`IOX_CTRL_RD];
                        s_nxt.skip = bus_wdata[`IOX_CTRL_SKIP];
                        s_nxt.ptr = bus_wdata[`IOX_CTRL_PTR_HI:`IOX_CTRL_PTR_LO];
                        if (bus_wdata[`IOX_CTRL_GO]) begin
                            if (scl_s && sda_s) begin // [R22]
                                s_nxt.busy = 1'b1;
                                s_nxt.nack = 1'b0;
                                s_nxt.refused = 1'b0;
                                s_nxt.abort = 1'b0;
                                s_nxt.slot = 1'b0;
                                s_nxt.remain = s_r.len;
                                if (bus_wdata[`IOX_CTRL_RD] && s_r.len == 8'h00) begin
                                    s_nxt.remain = 8'h01;
                                end
                                s_nxt.st = IOX_START;
                                s_nxt.q = 2'h0;
                                s_nxt.tcnt = 16'h0000;
                                // pointer kept in the device; skip the command byte
                                if (bus_wdata[`IOX_CTRL_RD] && bus_wdata[`IOX_CTRL_SKIP]) begin
                                    s_nxt.ph = IOX_PH_ADDR_R; // [R27]
                                end else begin
                                    s_nxt.ph = IOX_PH_ADDR_W;
                                end
                            end else begin
                                s_nxt.refused = 1'b1;
                            end
                        end
                    end
                end
                `IOX_OFF_ADDR: begin
                    if (!s_r.busy) begin
                        s_nxt.saddr = bus_wdata[6:0];
                    end
                end
                `IOX_OFF_LEN: begin
                    if (!s_r.busy) begin
                        s_nxt.len = bus_wdata[7:0];
                    end
                end
                `IOX_OFF_WDATA: begin
                    if (!s_r.busy) begin
                        s_nxt.wdata = bus_wdata;
                    end
                end
                default: ;
            endcase
        end

        // quarter-bit timer
        if (s_r.st != IOX_IDLE) begin
            if (tick) begin
                s_nxt.tcnt = 16'h0000;
            end else begin
                s_nxt.tcnt = s_r.tcnt + 16'h0001;
            end
        end

        if (tick) begin
            s_nxt.q = s_r.q + 2'h1;
            case (s_r.st)
                IOX_START: begin
                    case (s_r.q)
                        2'h0: s_nxt.sda_oe_n = 1'b1;
                        2'h1: s_nxt.scl_oe_n = 1'b1;
                        2'h2: s_nxt.sda_oe_n = 1'b0; // [R15]
                        default: begin
                            s_nxt.scl_oe_n = 1'b0;
                            s_nxt.st = IOX_BIT;
                            s_nxt.bitn = 4'h0;
                            s_nxt.sh = tx_byte(s_r, s_r.ph, s_r.slot);
                        end
                    endcase
                end
                IOX_BIT: begin
                    case (s_r.q)
                        2'h0: begin
                            // scl is low here, so sda may move
                            if (s_r.bitn == 4'h8) begin
                                if (s_r.ph == IOX_PH_RDATA) begin
                                    s_nxt.sda_oe_n = (s_r.remain == 8'h01) ||
                                        s_r.abort; // [R19] [R07] [R20]
                                end else begin
                                    s_nxt.sda_oe_n = 1'b1; // [R17]
                                end
                            end else if (s_r.ph == IOX_PH_RDATA) begin
                                s_nxt.sda_oe_n = 1'b1;
                            end else begin
                                s_nxt.sda_oe_n = s_r.sh[7]; // [R14]
                            end
                        end
                        2'h1: s_nxt.scl_oe_n = 1'b1;
                        2'h2: begin
                            if (s_r.bitn == 4'h8) begin
                                s_nxt.ack = ~sda_s; // [R18]
                            end else begin
                                s_nxt.sh = {s_r.sh[6:0], sda_s};
                            end
                        end
                        default: begin
                            s_nxt.scl_oe_n = 1'b0;
                            if (s_r.bitn != 4'h8) begin
                                s_nxt.bitn = s_r.bitn + 4'h1;
                            end else begin
                                s_nxt.bitn = 4'h0;
                                case (s_r.ph)
                                    IOX_PH_ADDR_W: begin
                                        if (!s_r.ack) begin
                                            s_nxt.nack = 1'b1; // [R26]
                                            s_nxt.st = IOX_STOP;
                                        end else begin
                                            s_nxt.ph = IOX_PH_CMD;
                                            s_nxt.sh = tx_byte(s_r, IOX_PH_CMD, s_r.slot);
                                        end
                                    end
                                    IOX_PH_CMD: begin
                                        if (!s_r.ack) begin
                                            s_nxt.nack = 1'b1;
                                            s_nxt.st = IOX_STOP;
                                        end else if (s_r.rd) begin
                                            s_nxt.st = IOX_START; // [R04]
                                            s_nxt.ph = IOX_PH_ADDR_R;
                                        end else if (s_r.remain == 8'h00) begin
                                            s_nxt.st = IOX_STOP;
                                        end else begin
                                            s_nxt.ph = IOX_PH_WDATA;
                                            s_nxt.sh = tx_byte(s_r, IOX_PH_WDATA, s_r.slot);
                                        end
                                    end
                                    IOX_PH_WDATA: begin
                                        s_nxt.slot = ~s_r.slot; // [R02]
                                        s_nxt.remain = s_r.remain - 8'h01;
                                        if (!s_r.ack) begin
                                            s_nxt.nack = 1'b1;
                                            s_nxt.st = IOX_STOP;
                                        end else if (s_r.remain == 8'h01) begin
                                            s_nxt.st = IOX_STOP;
                                        end else begin
                                            s_nxt.sh = tx_byte(s_r, IOX_PH_WDATA, ~s_r.slot); // [R03]
                                        end
                                    end
                                    IOX_PH_ADDR_R: begin
                                        if (!s_r.ack) begin
                                            s_nxt.nack = 1'b1; // [R26]
                                            s_nxt.st = IOX_STOP;
                                        end else begin
                                            s_nxt.ph = IOX_PH_RDATA;
                                        end
                                    end
                                    default: begin
                                        // byte was loaded by the device at the last ack
                                        if (s_r.slot) begin // [R05]
                                            s_nxt.rdata[15:8] = s_r.sh;
                                        end else begin
                                            s_nxt.rdata[7:0] = s_r.sh;
                                        end
                                        s_nxt.slot = ~s_r.slot; // [R06]
                                        s_nxt.remain = s_r.remain - 8'h01;
                                        if (s_r.remain == 8'h01) begin
                                            s_nxt.st = IOX_STOP; // [R21]
                                        end
                                    end
                                endcase
                                // an aborted read must nack first, else the device holds sda
                                if (s_r.abort && s_r.ph != IOX_PH_ADDR_R &&
                                        (s_r.ph != IOX_PH_RDATA || s_r.sda_oe_n)) begin
                                    s_nxt.st = IOX_STOP; // [R08]
                                end
                            end
                        end
                    endcase
                end
                IOX_STOP: begin
                    case (s_r.q)
                        2'h0: s_nxt.sda_oe_n = 1'b0;
                        2'h1: s_nxt.scl_oe_n = 1'b1;
                        2'h2: s_nxt.sda_oe_n = 1'b1; // [R16]
                        default: begin
                            s_nxt.st = IOX_IDLE;
                            s_nxt.busy = 1'b0;
                            s_nxt.abort = abort_wr;
                        end
                    endcase
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
            s_r.scl_oe_n <= 1'b1;
            s_r.sda_oe_n <= 1'b1;
            s_r.saddr <= `IOX_RST_ADDR;
            s_r.len <= `IOX_RST_LEN;
            s_r.ptr <= `IOX_RST_PTR;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bus_rdata = s_r.bus_rdata;
    assign scl_o = s_r.scl_o;
    assign scl_oe_n = s_r.scl_oe_n;
    assign sda_o = s_r.sda_o;
    assign sda_oe_n = s_r.sda_oe_n;
endmodule // iox_host

// file: test/iox_host_checker.sv
/*
 assertions on the pin side and software port of the expander bus host.
 assumes it is bound into iox_host and sees only that module's ports.
*/
`timescale 1ns/1ps
module iox_host_checker
    import iox_pkg::*;
#(
    parameter int QTR_CYC = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire iox_pkg::iox_byte_t bus_addr,
    input wire iox_pkg::iox_word_t bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire iox_pkg::iox_word_t bus_rdata,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe_n,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    input wire logic int_n_i
);
    localparam int QB = QTR_CYC + 2;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_drive_only_low: assert property (scl_o == 1'b0 && sda_o == 1'b0)
        else $error("pin drive value not low");
    a_data_stable_high: assert property ($rose(scl_oe_n) |-> $stable(sda_oe_n)[*3])
        else $error("sda moved while scl high");
    a_scl_low_time: assert property ($fell(scl_oe_n) |-> (!scl_oe_n)[*6])
        else $error("scl low phase too short");
    a_scl_high_time: assert property ($rose(scl_oe_n) |-> scl_oe_n[*6])
        else $error("scl high phase too short");
    a_start_on_idle: assert property ($fell(sda_oe_n) && scl_oe_n |-> $past(sda_i) && scl_i)
        else $error("start on a busy bus");
    a_start_then_clock: assert property ($fell(sda_oe_n) && scl_oe_n |-> ##[1:QB] !scl_oe_n)
        else $error("no clock after start");
    a_stop_to_idle: assert property ($rose(sda_oe_n) && scl_oe_n |=> (sda_oe_n && scl_oe_n)[*3])
        else $error("bus not idle after stop");
    a_reset_lines_idle: assert property ($rose(arst_n) |-> scl_oe_n && sda_oe_n)
        else $error("lines driven after reset");
    a_rdata_holds: assert property (!$past(bus_rd) |-> $stable(bus_rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property ($past(bus_rd) && $past(bus_addr) > 8'h14 |-> bus_rdata == 16'h0000)
        else $error("unmapped read not zero");
endmodule // iox_host_checker

bind iox_host iox_host_checker #(.QTR_CYC(QTR_CYC)) u_chk (.clk(clk), .arst_n(arst_n),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .int_n_i(int_n_i));

// file: test/iox_dev_model.sv
/*
 behavioural model of the 16-bit i2c port expander facing the host.
 assumes resolved scl/sda wires with pull-ups and pin levels set by the bench.
*/
`timescale 1ns/1ps
module iox_dev_model #(
    parameter logic [6:0] SADDR = 7'h24
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic [15:0] pins,
    output logic sda_oe_n,
    output logic int_n
);
    logic [7:0] rf [8];
    logic [15:0] snap = 16'h0000;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [2:0] ptr = 3'h0;
    logic [1:0] ph = 2'h0;
    logic act = 1'b0;
    logic first = 1'b0;
    int bc = 0;
    initial begin
        rf = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff};
        sda_oe_n = 1'b1;
    end
    assign int_n = ~|((pins ^ snap) & {rf[7], rf[6]});
    function automatic logic [7:0] rdv(input logic [2:0] p);
        if (p[2:1] != 2'b00) return rf[p];
        snap[p[0]*8 +: 8] = pins[p[0]*8 +: 8];
        return pins[p[0]*8 +: 8] ^ rf[{2'b10, p[0]}];
    endfunction
    always @(negedge sda) if (scl) begin
        act = 1'b1;
        bc = 0;
        ph = 2'h0;
        sda_oe_n = 1'b1;
    end
    always @(posedge sda) if (scl) begin
        act = 1'b0;
        sda_oe_n = 1'b1;
    end
    always @(posedge scl) if (act) begin
        if (bc < 8) sh = {sh[6:0], sda};
        else if (ph == 2'h3 && sda) act = 1'b0;
        bc = bc + 1;
    end
    always @(negedge scl) if (act) begin
        if (bc == 9) begin
            bc = 0;
            sda_oe_n = 1'b1;
            if (ph == 2'h3) begin
                if (!first) ptr = ptr ^ 3'h1;
                first = 1'b0;
                tx = rdv(ptr);
                sda_oe_n = tx[7];
            end
        end else if (bc == 8) begin
            sda_oe_n = 1'b1;
            if (ph == 2'h0 && sh[7:1] != SADDR) act = 1'b0;
            else if (ph != 2'h3) begin
                sda_oe_n = 1'b0;
                if (ph == 2'h0) begin
                    ph = sh[0] ? 2'h3 : 2'h1;
                    first = 1'b1;
                end else if (ph == 2'h1) begin
                    ptr = sh[2:0];
                    ph = 2'h2;
                end else begin
                    if (ptr[2:1] != 2'b00) rf[ptr] = sh;
                    ptr = ptr ^ 3'h1;
                end
            end
        end else if (ph == 2'h3) sda_oe_n = tx[7 - bc];
    end
endmodule // iox_dev_model

// file: test/iox_host_bench.sv
/*
 self-checking bench of the expander bus host against the expander model.
 assumes iox_cfg.svh on the include path and a shortened quarter-bit count.
*/
`timescale 1ns/1ps
`include "iox_cfg.svh"
module iox_host_bench;
    import iox_pkg::*;
    localparam int QTR = 4;
    localparam logic [6:0] DEV = 7'h24;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    iox_byte_t bus_addr = 8'h00;
    iox_word_t bus_wdata = 16'h0000;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    iox_word_t bus_rdata;
    logic scl_o;
    logic scl_oe_n;
    logic sda_o;
    logic sda_oe_n;
    logic dev_sda_oe_n;
    logic int_n;
    logic ext_hold = 1'b0;
    logic [15:0] pins = 16'h0000;
    int mismatches = 0;
    int total_checks = 0;
    wire scl = scl_oe_n;
    wire sda = sda_oe_n & dev_sda_oe_n & ~ext_hold;
    always #10 clk = ~clk;
    iox_host #(.QTR_CYC(QTR)) dut (.clk(clk), .arst_n(arst_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .int_n_i(int_n));
    iox_dev_model #(.SADDR(DEV)) u_dev (.scl(scl), .sda(sda), .pins(pins),
        .sda_oe_n(dev_sda_oe_n), .int_n(int_n));
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input iox_word_t got, input iox_word_t exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input iox_byte_t a, input iox_word_t d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(input iox_byte_t a, output iox_word_t v);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 v = bus_rdata;
    endtask
    task automatic chk(input iox_byte_t a, input iox_word_t m, input iox_word_t e);
        iox_word_t v;
        rd(a, v);
        check(v & m, e);
    endtask
    task automatic xfer(input logic [6:0] sa, input iox_byte_t n, input iox_word_t d,
            input iox_word_t c);
        iox_word_t v;
        wr(`IOX_OFF_ADDR, {9'h000, sa});
        wr(`IOX_OFF_LEN, {8'h00, n});
        wr(`IOX_OFF_WDATA, d);
        wr(`IOX_OFF_CTRL, c);
        v = 16'h0001;
        for (int i = 0; i < 4000 && v[0] !== 1'b0; i++) rd(`IOX_OFF_STAT, v);
        if (v[0] !== 1'b0) begin
            mismatches++;
            close_out();
        end
    endtask
    task automatic int_is(input logic on);
        repeat (4) @(posedge clk);
        chk(`IOX_OFF_STAT, 16'h0004, on ? 16'h0004 : 16'h0000);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk(`IOX_OFF_ADDR, 16'hffff, 16'h0000);
        chk(`IOX_OFF_LEN, 16'hffff, 16'h0001);
        chk(`IOX_OFF_STAT, 16'h001f, 16'h0008);
        chk(8'h18, 16'hffff, 16'h0000);
        $display("test reset done");
        xfer(DEV, 8'h03, 16'ha55a, 16'h0031);
        chk(`IOX_OFF_STAT, 16'h0003, 16'h0000);
        xfer(DEV, 8'h03, 16'h0000, 16'h0023);
        chk(`IOX_OFF_RDATA, 16'hffff, 16'h5aa5);
        $display("test pair done");
        xfer(DEV, 8'h01, 16'h00f0, 16'h0061);
        xfer(DEV, 8'h01, 16'h0000, 16'h0007);
        chk(`IOX_OFF_RDATA, 16'h00ff, 16'h00ff);
        xfer(DEV, 8'h01, 16'h000f, 16'h0041);
        xfer(DEV, 8'h01, 16'h0000, 16'h0003);
        chk(`IOX_OFF_RDATA, 16'h00ff, 16'h000f);
        pins[0] <= 1'b1;
        int_is(1'b0);
        pins[4] <= 1'b1;
        int_is(1'b1);
        xfer(DEV, 8'h01, 16'h0000, 16'h0013);
        int_is(1'b1);
        xfer(DEV, 8'h01, 16'h0000, 16'h0003);
        chk(`IOX_OFF_RDATA, 16'h00ff, 16'h001e);
        int_is(1'b0);
        pins[12] <= 1'b1;
        int_is(1'b1);
        pins[12] <= 1'b0;
        int_is(1'b0);
        pins[0] <= 1'b0;
        int_is(1'b0);
        xfer(DEV, 8'h01, 16'h00ff, 16'h0061);
        int_is(1'b1);
        $display("test interrupt done");
        xfer(7'h25, 8'h01, 16'h0000, 16'h0001);
        chk(`IOX_OFF_STAT, 16'h0003, 16'h0002);
        ext_hold <= 1'b1;
        repeat (4) @(posedge clk);
        wr(`IOX_OFF_CTRL, 16'h0001);
        chk(`IOX_OFF_STAT, 16'h0011, 16'h0010);
        ext_hold <= 1'b0;
        $display("test refusal done");
        wr(`IOX_OFF_ADDR, {9'h000, DEV});
        wr(`IOX_OFF_LEN, 16'h00ff);
        wr(`IOX_OFF_CTRL, 16'h0021);
        wr(`IOX_OFF_CTRL, 16'h0008);
        xfer(DEV, 8'h01, 16'h0000, 16'h0000);
        chk(`IOX_OFF_STAT, 16'h0003, 16'h0000);
        chk(`IOX_OFF_LEN, 16'hffff, 16'h00ff);
        $display("test abort done");
        close_out();
    end
endmodule // iox_host_bench
